// [verilog/csp_pkg.sv]
`default_nettype none
package csp_pkg;
    // Register word offsets on the APB side
    localparam logic [7:0] CSP_OFF_CTRL = 8'h00;
    localparam logic [7:0] CSP_OFF_PROTECT = 8'h04;
    localparam logic [7:0] CSP_OFF_DIVIDER = 8'h08;
    localparam logic [7:0] CSP_OFF_SHIFT = 8'h0c;
    localparam logic [7:0] CSP_OFF_STATUS = 8'h10;
    localparam logic [7:0] CSP_OFF_PORT = 8'h14;
    // Control register fields
    localparam int CSP_CTRL_TAP_LO = 0;
    localparam int CSP_CTRL_PFE = 3;
    localparam int CSP_CTRL_EDGE = 4;
    localparam int CSP_CTRL_MSB = 5;
    localparam int CSP_CTRL_SRC = 6;
    localparam int CSP_CTRL_IDLE = 7;
    // Protect register unlock bit
    localparam int CSP_PROT_UNLOCK = 2;
    // Port register fields (used while pin functions are off)
    localparam int CSP_PORT_SOUT = 0;
    localparam int CSP_PORT_CLK = 1;
    localparam int CSP_PORT_SOUT_DRV = 2;
    localparam int CSP_PORT_CLK_DRV = 3;
    // Prescaler taps
    localparam logic [1:0] CSP_TAP_DIV1 = 2'h0;
    localparam logic [1:0] CSP_TAP_DIV8 = 2'h1;
    localparam logic [1:0] CSP_TAP_DIV32 = 2'h2;
    localparam logic [4:0] CSP_DIV8_LAST = 5'h07;
    localparam logic [4:0] CSP_DIV32_LAST = 5'h1f;
    // Reset values and byte length
    localparam logic [7:0] CSP_CTRL_RESET = 8'h00;
    localparam logic [7:0] CSP_DIVIDER_RESET = 8'h00;
    localparam logic [7:0] CSP_SHIFT_RESET = 8'h00;
    localparam logic [3:0] CSP_PORT_RESET = 4'h0;
    localparam logic [2:0] CSP_LAST_BIT = 3'h7;

    // Bit that leaves the shift register next
    function automatic logic csp_out_bit(input logic [7:0] sh, input logic msb);
        csp_out_bit = msb ? sh[7] : sh[0];
    endfunction

    // Shift register after one bit has been taken in
    function automatic logic [7:0] csp_shift_in(input logic [7:0] sh, input logic msb,
                                                input logic b);
        csp_shift_in = msb ? {sh[6:0], b} : {b, sh[7:1]};
    endfunction
endpackage
`default_nettype wire

// [verilog/csp_link_if.sv]
`default_nettype none
// Serial link between the channel and its peer; pull-ups resolve released lines
interface csp_link_if;
    logic dev_clk_o;      // Clock driven by the channel
    logic dev_clk_oe_n;   // Low while the channel drives the clock
    logic dev_sout_o;     // Channel serial data out
    logic dev_sout_oe_n;  // Low while the channel drives data out
    logic peer_clk_o;     // Clock driven by the peer
    logic peer_clk_oe_n;  // Low while the peer drives the clock
    logic peer_sdo_o;     // Peer data, lands on the channel's serial input
    logic peer_sdo_oe_n;  // Low while the peer drives its data
    logic sclk;           // Resolved clock wire
    logic sout;           // Resolved channel-to-peer data wire
    logic sin;            // Resolved peer-to-channel data wire

    // Released wires float high through pull-ups
    assign sclk = !dev_clk_oe_n ? dev_clk_o : (!peer_clk_oe_n ? peer_clk_o : 1'b1);
    assign sout = !dev_sout_oe_n ? dev_sout_o : 1'b1;
    assign sin = !peer_sdo_oe_n ? peer_sdo_o : 1'b1;

    modport dev (
        output dev_clk_o, dev_clk_oe_n, dev_sout_o, dev_sout_oe_n,
        input sclk, sin
    );
    modport peer (
        output peer_clk_o, peer_clk_oe_n, peer_sdo_o, peer_sdo_oe_n,
        input sclk, sout
    );
endinterface
`default_nettype wire

// [verilog/csp_clk_div.sv]
`default_nettype none
// Counts step pulses and ticks once every limit+1 of them
module csp_clk_div #(
    parameter int W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clear,
    input wire logic step,
    input wire logic [W-1:0] limit,
    output logic tick
);
    logic [W-1:0] cnt_q;  // Steps seen since last tick

    // Clear restarts the half period so the first edge is a full one away
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
            tick <= 1'b0;
        end else if (clear) begin
            cnt_q <= '0;
            tick <= 1'b0;
        end else if (step) begin
            if (cnt_q == limit) begin
                cnt_q <= '0;
                tick <= 1'b1;
            end else begin
                cnt_q <= cnt_q + 1'b1;
                tick <= 1'b0;
            end
        end else begin
            tick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// [verilog/csp_channel.sv]
`default_nettype none
// Clock-synchronous serial channel with APB register access
module csp_channel
    import csp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic xfer_irq,
    csp_link_if.dev link
);
    typedef enum logic [1:0] {CSP_IDLE, CSP_SHIFT, CSP_HOLD} csp_state_type;

    csp_state_type state_q;  // Transfer state
    logic [7:0] ctrl_q;      // Control register
    logic [7:0] div_q;       // Divider value n
    logic [7:0] sh_q;        // Shift/data register
    logic [3:0] port_q;      // Port fallback latches and drives
    logic unlock_q;          // Control write armed for one transfer
    logic [2:0] bit_q;       // Bits completed in this byte
    logic clk_q;             // Internal transfer clock level
    logic sout_q;            // Data bit being presented
    logic drv_q;             // Internal mode: output actively driven
    logic [4:0] pre_q;       // Prescaler counter
    logic clk_s1_q, clk_s2_q, clk_s3_q;  // Clock pin synchroniser and history
    logic sin_s1_q, sin_s2_q;            // Data input synchroniser
    logic tick;              // Half period elapsed

    // Control fields
    wire logic int_clk = ctrl_q[CSP_CTRL_SRC];
    wire logic pfe = ctrl_q[CSP_CTRL_PFE];
    wire logic msb = ctrl_q[CSP_CTRL_MSB];
    wire logic idle_lvl = ctrl_q[CSP_CTRL_IDLE];
    wire logic idle_clk = ~ctrl_q[CSP_CTRL_EDGE];  // Edge select 0 rests high

    // APB phases: pready comes one cycle into the access phase
    wire logic acc = psel && penable;
    wire logic acc_first = acc && !pready;
    wire logic commit = acc && pready;
    wire logic wr = commit && pwrite;
    wire logic wr_shift = wr && (paddr == CSP_OFF_SHIFT) && (state_q != CSP_SHIFT);

    // Prescaler taps
    logic fj;
    always_comb begin
        case (ctrl_q[CSP_CTRL_TAP_LO +: 2])
            CSP_TAP_DIV1: fj = 1'b1;
            CSP_TAP_DIV8: fj = (pre_q[2:0] == CSP_DIV8_LAST[2:0]);
            CSP_TAP_DIV32: fj = (pre_q == CSP_DIV32_LAST);
            default: fj = 1'b1;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_q <= '0;
        end else begin
            pre_q <= pre_q + 1'b1;
        end
    end

    // Half period is n+1 tap pulses, so a full period is 2(n+1)
    csp_clk_div #(.W(8)) u_div (
        .pclk(pclk),
        .presetn(presetn),
        .clear(wr_shift || state_q == CSP_IDLE),
        .step(fj && int_clk),
        .limit(div_q),
        .tick(tick)
    );

    // Pin inputs pass two flops; the third only keeps edge history
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_s1_q <= 1'b1;
            clk_s2_q <= 1'b1;
            clk_s3_q <= 1'b1;
            sin_s1_q <= 1'b1;
            sin_s2_q <= 1'b1;
        end else begin
            clk_s1_q <= link.sclk;
            clk_s2_q <= clk_s1_q;
            clk_s3_q <= clk_s2_q;
            sin_s1_q <= link.sin;
            sin_s2_q <= sin_s1_q;
        end
    end

    // Lead edge leaves the idle level, trail edge returns to it
    wire logic ext_edge = (clk_s2_q != clk_s3_q);
    wire logic in_shift = (state_q == CSP_SHIFT);
    wire logic lead = in_shift && (int_clk ? (tick && clk_q == idle_clk)
                                           : (ext_edge && clk_s3_q == idle_clk));
    wire logic trail = in_shift && (int_clk ? (tick && clk_q != idle_clk)
                                            : (ext_edge && clk_s2_q == idle_clk));
    wire logic last = trail && (bit_q == CSP_LAST_BIT);

    // Transfer state machine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= CSP_IDLE;
        end else begin
            case (state_q)
                CSP_IDLE: begin
                    if (wr_shift) begin
                        state_q <= CSP_SHIFT;
                    end
                end
                CSP_SHIFT: begin
                    if (last) begin
                        // Internal mode keeps the last bit; external returns at once
                        state_q <= int_clk ? CSP_HOLD : CSP_IDLE;
                    end
                end
                CSP_HOLD: begin
                    if (wr_shift) begin
                        state_q <= CSP_SHIFT;
                    end else if (tick) begin
                        state_q <= CSP_IDLE;
                    end
                end
                default: state_q <= CSP_IDLE;
            endcase
        end
    end

    // Shift register: loaded by software, fills from the input pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh_q <= CSP_SHIFT_RESET;
        end else if (wr_shift) begin
            sh_q <= pwdata[7:0];
        end else if (trail) begin
            sh_q <= csp_shift_in(sh_q, msb, sin_s2_q);
        end
    end

    // Bit counter; extra external pulses after the eighth are not counted
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_q <= '0;
        end else if (wr_shift) begin
            bit_q <= '0;
        end else if (trail) begin
            bit_q <= bit_q + 1'b1;
        end
    end

    // Internal clock toggles only while shifting, rests at idle otherwise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_q <= 1'b1;
        end else if (!in_shift) begin
            clk_q <= idle_clk;
        end else if (int_clk && tick) begin
            clk_q <= ~clk_q;
        end
    end

    // Data out changes on the lead edge; idle level in the idle state and on a shift write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sout_q <= 1'b0;
        end else if (lead) begin
            sout_q <= csp_out_bit(sh_q, msb);
        end else if (state_q == CSP_IDLE || wr_shift) begin
            sout_q <= idle_lvl;
        end
    end

    // Internal mode drives data from first lead edge until hold ends
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drv_q <= 1'b0;
        end else if (wr_shift || state_q == CSP_IDLE) begin
            drv_q <= 1'b0;
        end else if (lead) begin
            drv_q <= 1'b1;
        end else if (state_q == CSP_HOLD && tick) begin
            drv_q <= 1'b0;
        end
    end

    // One-cycle request at the trail edge of the eighth pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xfer_irq <= 1'b0;
        end else begin
            xfer_irq <= last;
        end
    end

    // Pins: serial functions only with pin enable, else port latches
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link.dev_clk_o <= 1'b1;
            link.dev_clk_oe_n <= 1'b1;
            link.dev_sout_o <= 1'b1;
            link.dev_sout_oe_n <= 1'b1;
        end else if (pfe) begin
            link.dev_clk_o <= clk_q;
            link.dev_clk_oe_n <= ~int_clk;
            link.dev_sout_o <= sout_q;
            link.dev_sout_oe_n <= int_clk ? ~drv_q : 1'b0;
        end else begin
            link.dev_clk_o <= port_q[CSP_PORT_CLK];
            link.dev_clk_oe_n <= ~port_q[CSP_PORT_CLK_DRV];
            link.dev_sout_o <= port_q[CSP_PORT_SOUT];
            link.dev_sout_oe_n <= ~port_q[CSP_PORT_SOUT_DRV];
        end
    end

    // Unlock lasts for exactly the next completed transfer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unlock_q <= 1'b0;
        end else if (commit) begin
            unlock_q <= wr && paddr == CSP_OFF_PROTECT && pwdata[CSP_PROT_UNLOCK];
        end
    end

    // Software-written registers; control needs the unlock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= CSP_CTRL_RESET;
            div_q <= CSP_DIVIDER_RESET;
            port_q <= CSP_PORT_RESET;
        end else if (wr) begin
            if (paddr == CSP_OFF_CTRL && unlock_q) begin
                ctrl_q <= pwdata[7:0];
            end
            if (paddr == CSP_OFF_DIVIDER) begin
                div_q <= pwdata[7:0];
            end
            if (paddr == CSP_OFF_PORT) begin
                port_q <= pwdata[3:0];
            end
        end
    end

    // APB answer: one wait state, read data and error set with pready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= acc_first;
            pslverr <= 1'b0;
            prdata <= '0;
            if (acc_first) begin
                case (paddr)
                    CSP_OFF_CTRL: prdata <= {24'h000000, ctrl_q};
                    CSP_OFF_PROTECT: prdata <= {29'h0, unlock_q, 2'h0};
                    CSP_OFF_DIVIDER: prdata <= '0;  // Write-only
                    CSP_OFF_SHIFT: prdata <= {24'h000000, sh_q};
                    CSP_OFF_STATUS: prdata <= {30'h0, state_q == CSP_HOLD, in_shift};
                    CSP_OFF_PORT: prdata <= {28'h0, port_q};
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// [verilog/csp_peer.sv]
`default_nettype none
// Far-end peer: either supplies eight clock pulses or follows the channel's clock
module csp_peer
    import csp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,            // One-cycle pulse, begins a byte
    input wire logic [7:0] tx_byte,    // Byte to send, taken with start
    input wire logic gen_clock,        // 1: peer makes the clock
    input wire logic edge_sel,         // Same polarity as the channel
    input wire logic msb_first,        // Same bit order as the channel
    input wire logic [7:0] half_limit, // Half period is half_limit+1 cycles
    output logic busy,
    output logic done,
    output logic [7:0] rx_byte,
    csp_link_if.peer link
);
    logic [7:0] sh_q;        // Peer shift register
    logic [2:0] bit_q;       // Trail edges seen
    logic clk_q;             // Generated clock level
    logic clk_s1_q, clk_s2_q, clk_s3_q;  // Clock synchroniser when following
    logic dat_s1_q, dat_s2_q;            // Channel data synchroniser
    logic tick;

    wire logic idle_clk = ~edge_sel;
    wire logic ext_edge = (clk_s2_q != clk_s3_q);
    wire logic lead = busy && (gen_clock ? (tick && clk_q == idle_clk)
                                         : (ext_edge && clk_s3_q == idle_clk));
    wire logic trail = busy && (gen_clock ? (tick && clk_q != idle_clk)
                                          : (ext_edge && clk_s2_q == idle_clk));
    wire logic last = trail && (bit_q == CSP_LAST_BIT);

    csp_clk_div #(.W(8)) u_half (
        .pclk(pclk),
        .presetn(presetn),
        .clear(!busy),
        .step(gen_clock),
        .limit(half_limit),
        .tick(tick)
    );

    // Synchronisers for the channel's lines
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_s1_q <= 1'b1;
            clk_s2_q <= 1'b1;
            clk_s3_q <= 1'b1;
            dat_s1_q <= 1'b1;
            dat_s2_q <= 1'b1;
        end else begin
            clk_s1_q <= link.sclk;
            clk_s2_q <= clk_s1_q;
            clk_s3_q <= clk_s2_q;
            dat_s1_q <= link.sout;
            dat_s2_q <= dat_s1_q;
        end
    end

    // Byte sequencing; clock stops after the eighth pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy <= 1'b0;
            done <= 1'b0;
            bit_q <= '0;
            sh_q <= '0;
            rx_byte <= '0;
        end else begin
            done <= last;
            if (start && !busy) begin
                busy <= 1'b1;
                bit_q <= '0;
                sh_q <= tx_byte;
            end else if (trail) begin
                sh_q <= csp_shift_in(sh_q, msb_first, dat_s2_q);
                bit_q <= bit_q + 1'b1;
                if (last) begin
                    busy <= 1'b0;
                    rx_byte <= csp_shift_in(sh_q, msb_first, dat_s2_q);
                end
            end
        end
    end

    // Clock rests at idle between bytes so the channel may be written
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_q <= 1'b1;
        end else if (!busy) begin
            clk_q <= idle_clk;
        end else if (gen_clock && tick) begin
            clk_q <= ~clk_q;
        end
    end

    // Link outputs: data changes on lead edges, clock driven only when generated
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link.peer_clk_o <= 1'b1;
            link.peer_clk_oe_n <= 1'b1;
            link.peer_sdo_o <= 1'b1;
            link.peer_sdo_oe_n <= 1'b1;
        end else begin
            link.peer_clk_o <= clk_q;
            link.peer_clk_oe_n <= ~gen_clock;
            link.peer_sdo_oe_n <= 1'b0;
            if (lead) begin
                link.peer_sdo_o <= csp_out_bit(sh_q, msb_first);
            end
        end
    end
endmodule
`default_nettype wire

// [dv/csp_link_chk.sv]
`default_nettype none
// Watches the link wires for the channel's clocking and hold timing
module csp_link_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic dev_clk_o,
    input wire logic dev_clk_oe_n,
    input wire logic dev_sout_o,
    input wire logic dev_sout_oe_n,
    input wire logic peer_clk_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_q; // Clock level one cycle back
    logic [4:0] cnt_q; // Edges so far in this frame
    logic [15:0] gap_q; // Cycles since the last edge
    logic [15:0] last_q; // Previous gap
    logic edge_seen; // Channel clock edge inside a frame
    assign edge_seen = !dev_clk_oe_n && !dev_sout_oe_n && (dev_clk_o != clk_q);
    // Frame bookkeeping; released data output ends the frame
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_q <= 1'b1;
            cnt_q <= 5'h00;
            gap_q <= 16'h0000;
            last_q <= 16'h0000;
        end else begin
            clk_q <= dev_clk_o;
            cnt_q <= dev_sout_oe_n ? 5'h00 : cnt_q + {4'h0, edge_seen};
            gap_q <= edge_seen ? 16'h0001 : gap_q + 16'h0001;
            last_q <= edge_seen ? gap_q : last_q;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_no_fight: assert property (!(!dev_clk_oe_n && !peer_clk_oe_n))
        else $error("clock driven from both ends");
    a_pulse_max: assert property (cnt_q <= 5'h10)
        else $error("more than eight clock pulses");
    a_pulse_full: assert property ($rose(dev_sout_oe_n) && !$past(dev_clk_oe_n) |-> cnt_q == 5'h10)
        else $error("frame ended without eight pulses");
    a_even_gaps: assert property (edge_seen && cnt_q >= 5'h02 |-> gap_q == last_q)
        else $error("uneven half periods");
    a_change_lead: assert property ($changed(dev_sout_o) && !dev_sout_oe_n && !dev_clk_oe_n
        && !$past(dev_sout_oe_n) |-> edge_seen && !cnt_q[0])
        else $error("data changed off the leading edge");
    a_hold_stable: assert property (cnt_q == 5'h10 && !dev_sout_oe_n |=> dev_sout_oe_n
        || $stable(dev_sout_o))
        else $error("last bit not held");
    a_hold_release: assert property (edge_seen && cnt_q == 5'h0f |-> ##[1:300] dev_sout_oe_n)
        else $error("data output not released");
    a_clk_rests: assert property (cnt_q == 5'h10 |=> $stable(dev_clk_o))
        else $error("clock moved after the byte");
endmodule
`default_nettype wire

// [dv/tb_clock_sync_serial_port.sv]
`default_nettype none
// Channel and peer face each other; bytes are checked both ways
module tb_clock_sync_serial_port
    import csp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, xfer_irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic start, gen_clock, edge_sel, msb_first, busy, done;
    logic [7:0] tx_byte, half_limit, rx_byte;
    int fail_count, comparisons, cyc;
    logic [33:0] rd_q[$]; // Expected reads: check data, error flag, data
    logic [7:0] rx_q[$]; // Bytes the peer should receive
    csp_link_if csp_link_if_inst ();
    csp_channel csp_channel_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .xfer_irq(xfer_irq),
        .link(csp_link_if_inst));
    csp_peer csp_peer_inst (.pclk(pclk), .presetn(presetn), .start(start),
        .tx_byte(tx_byte), .gen_clock(gen_clock), .edge_sel(edge_sel),
        .msb_first(msb_first), .half_limit(half_limit), .busy(busy), .done(done),
        .rx_byte(rx_byte), .link(csp_link_if_inst));
    csp_link_chk csp_link_chk_inst (.pclk(pclk), .presetn(presetn),
        .dev_clk_o(csp_link_if_inst.dev_clk_o), .dev_clk_oe_n(csp_link_if_inst.dev_clk_oe_n),
        .dev_sout_o(csp_link_if_inst.dev_sout_o),
        .dev_sout_oe_n(csp_link_if_inst.dev_sout_oe_n),
        .peer_clk_oe_n(csp_link_if_inst.peer_clk_oe_n));
    // Free-running 50 MHz clock
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    // Counts and reports one comparison
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    task end_of_test;
        if (fail_count == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // One APB transfer; an idle edge follows so psel is never set twice at once
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rd(input logic [7:0] a, input logic [33:0] e);
        rd_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    // One byte each way; the peer clocks in external mode
    task automatic xfer(input logic [7:0] cv, input logic [7:0] n);
        logic [7:0] b;
        logic [7:0] p;
        b = 8'($urandom);
        p = 8'($urandom);
        gen_clock <= 1'b0; // Peer lets go before the channel may drive
        wr(CSP_OFF_PROTECT, 32'h1 << CSP_PROT_UNLOCK);
        wr(CSP_OFF_CTRL, {24'h0, cv});
        wr(CSP_OFF_DIVIDER, {24'h0, n});
        gen_clock <= !cv[CSP_CTRL_SRC];
        edge_sel <= cv[CSP_CTRL_EDGE];
        msb_first <= cv[CSP_CTRL_MSB];
        // Half period must cover the round trip through both synchronisers
        half_limit <= 8'h0c;
        tx_byte <= p;
        // Let the clock wire settle at its new idle level before the shift write
        repeat (6) @(posedge pclk);
        rx_q.push_back(b);
        if (!cv[CSP_CTRL_SRC])
            chk("idle level", {31'h0, cv[CSP_CTRL_IDLE]}, {31'h0, csp_link_if_inst.sout});
        if (cv[CSP_CTRL_SRC]) begin
            // Peer must follow before the channel starts clocking
            start <= 1'b1;
            @(posedge pclk);
            start <= 1'b0;
            wr(CSP_OFF_SHIFT, {24'h0, b});
            wr(CSP_OFF_SHIFT, {24'h0, ~b});
        end else begin
            wr(CSP_OFF_SHIFT, {24'h0, b});
            start <= 1'b1;
            @(posedge pclk);
            start <= 1'b0;
        end
        while (xfer_irq !== 1'b1) @(posedge pclk);
        while (busy !== 1'b0 || (cv[CSP_CTRL_SRC] && csp_link_if_inst.dev_sout_oe_n !== 1'b1))
            @(posedge pclk);
        rd(CSP_OFF_STATUS, {2'b10, 32'h0});
        rd(CSP_OFF_SHIFT, {2'b10, 24'h0, p});
    endtask
    // Watches results and takes the oldest expectation for each
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (psel && penable && pready === 1'b1 && !pwrite && rd_q.size() > 0) begin
            if (rd_q[0][33])
                chk("read data", rd_q[0][31:0], prdata);
            chk("error flag", {31'h0, rd_q[0][32]}, {31'h0, pslverr});
            void'(rd_q.pop_front());
        end
        if (done === 1'b1 && rx_q.size() > 0) begin
            chk("peer byte", {24'h0, rx_q[0]}, {24'h0, rx_byte});
            void'(rx_q.pop_front());
        end
        if (cyc == 60000) begin
            fail_count++;
            end_of_test();
        end
    end
    // Reset, every mode, then register access checks
    initial begin
        logic [7:0] cv;
        logic [7:0] n;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {start, gen_clock, edge_sel, msb_first, tx_byte, half_limit} = '0;
        presetn = 1'b0;
        fail_count = 0;
        comparisons = 0;
        cyc = 0;
        void'($urandom(32'ha463));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("sout released", 32'h1, {31'h0, csp_link_if_inst.dev_sout_oe_n});
        rd(CSP_OFF_CTRL, {2'b10, 24'h0, CSP_CTRL_RESET});
        for (int k = 0; k < 8; k++) begin
            // Edge, bit order, source and tap all walk through their values
            cv = {1'($urandom), !k[2], k[1], k[0], 1'b1, 1'b0, 2'(k % 3)};
            n = (k % 3 == 0) ? 8'(7 + $urandom % 5) : 8'h01;
            xfer(cv, n);
        end
        wr(CSP_OFF_CTRL, 32'h0);
        rd(CSP_OFF_CTRL, {2'b10, 24'h0, cv});
        rd(CSP_OFF_DIVIDER, {2'b10, 32'h0});
        rd(8'h20, {2'b01, 32'h0});
        end_of_test();
    end
endmodule
`default_nettype wire
